// >>> hdl/enc_latch_cfg.svh
// constants of the encoder latch and comparator channel
`ifndef ENC_LATCH_CFG_SVH
`define ENC_LATCH_CFG_SVH

// ------------------------------------------------------------------
// configuration word numbers
// ------------------------------------------------------------------
`define WORD_W 4
`define WORD_LO45 4'h4
`define WORD_HI45 4'h5
`define WORD_LO67 4'h6
`define WORD_HI67 4'h7
`define WORD_CTRL 4'h8
`define WORD_STATUS 4'hc
`define WORD_CONFIG 4'he

// ------------------------------------------------------------------
// module configuration word fields
// ------------------------------------------------------------------
`define CFG_LEVEL 0
`define CFG_INVLEVEL 2
`define CFG_COMP_ON 3
`define CFG_HOME_CLR 4
`define CFG_SWITCH 5
`define CFG_SET_REF 6
`define CFG_REF_INV 7
`define CFG_UNSIGNED 10
`define CFG_DIR_INV 11
`define CFG_RESET 16'h0000

// ------------------------------------------------------------------
// control word and status word fields
// ------------------------------------------------------------------
`define CTRL_TAKE 8
`define CTRL_NEG 10
`define CTRL_POS 11
`define CTRL_RESET 16'h0000
`define STAT_REFD 7
`define STAT_NEG 10
`define STAT_POS 11
`define MIN_DIFF_RESET 32'h0000_0000

`endif

// >>> hdl/enc_latch_channel.sv
// incremental encoder channel: counter, homing, comparator and latching
//
// Behaviour
// RULE1: homing outranks comparator, comparator outranks latching on shared inputs.
// RULE2: host enables only one of homing, comparator or latching at once.
// RULE3: rising latch request bit arms latching and captures counter as comparison value.
// RULE4: zero minimum difference latches counter directly on the selected reference edge.
// RULE5: nonzero minimum difference puts counter in a holding register on each edge.
// RULE6: held minus comparison above minimum difference accepts value, sets valid bit.
// RULE7: otherwise value is discarded and the next matching edge is tried.
// RULE8: reading word 12 returns live status and copies it to status data word.
// RULE9: reading word 14 returns the module code in its upper byte.
// RULE10: configuration bit 11 inverts the counting direction.
// RULE11: bit 10 selects signed or unsigned cyclic counting and window compare.
// RULE12: host writes zero to bits 8-9, 12, 14-15 and 1 for encoder mode.
// RULE13: configuration bit 7 inverts the reference pulse polarity.
// RULE14: bit 6 set clears counter and sets referenced; clear drops referenced.
// RULE15: bit 5 makes referencing need both pulse and reference enable switch.
// RULE16: bit 4 set clears counter on each reference event.
// RULE17: bit 3 enables comparator; otherwise output 1 follows the digital output.
// RULE18: inside the threshold window output is bit 0 level, inverted by bit 2.
// RULE19: rising control bit 8 takes words 4+5 as minimum difference, 6+7 as force.
// RULE20: each request latches once; host clears it and waits for status zero.
// RULE21: outside the window the output takes the opposite level.
`timescale 1ns/1ps
`default_nettype none
`include "enc_latch_cfg.svh"
module enc_latch_channel
  import enc_latch_pkg::*;
#(
  parameter logic [7:0] MODULE_CODE = 8'h5a // arbitrary identification value
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire enc_pins_type pins_i,
  input wire logic dout_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [`WORD_W-1:0] cfg_addr_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  output logic [15:0] status_word_o,
  output logic [31:0] count_o,
  output logic [31:0] force_value_o,
  output logic comp_out_o
);

  // ------------------------------------------------------------------
  // pin synchronisation and quadrature evaluation
  // ------------------------------------------------------------------
  enc_pins_type pins_sync;
  logic step;
  logic up;

  pin_sync #(.WIDTH(4)) pin_sync_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pins_i),
    .sync_o(pins_sync)
  );

  quad_decode quad_decode_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .a_i(pins_sync.enc_a),
    .b_i(pins_sync.enc_b),
    .step_o(step),
    .up_o(up)
  );

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [15:0] config_reg, config_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [31:0] stage45_reg, stage45_next;
  logic [31:0] stage67_reg, stage67_next;
  logic [31:0] min_diff_reg, min_diff_next;
  logic [31:0] force_reg, force_next;
  logic [31:0] count_reg, count_next;
  logic refd_reg, refd_next;
  logic ref_prev_reg, ref_prev_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] stat_data_reg, stat_data_next;
  logic comp_reg, comp_next;
  latch_state_type state_reg [2], state_next [2];
  logic [31:0] cmp_reg [2], cmp_next [2];
  logic [31:0] hold_reg [2], hold_next [2];
  logic [31:0] latched_reg [2], latched_next [2];
  logic [1:0] valid_reg, valid_next;

  logic wr_cfg;
  logic ref_level;
  logic ref_rise;
  logic ref_fall;
  logic home_en;
  logic comp_en;
  logic latch_en;
  logic home_evt;
  logic in_window;
  logic [1:0] req_rise;
  logic [1:0] req_now;
  logic [1:0] ref_edge;
  logic [1:0] accept;
  logic [31:0] diff [2];
  logic [15:0] status_live;

  assign wr_cfg = cfg_wr_i && (cfg_addr_i == `WORD_CONFIG);
  assign ref_level = pins_sync.ref_pulse ^ config_reg[`CFG_REF_INV]; // RULE13
  assign ref_rise = ref_level && !ref_prev_reg;
  assign ref_fall = !ref_level && ref_prev_reg;
  assign home_en = config_reg[`CFG_HOME_CLR];
  assign comp_en = config_reg[`CFG_COMP_ON] && !home_en; // RULE1
  assign latch_en = !config_reg[`CFG_COMP_ON] && !home_en; // RULE1
  assign home_evt = home_en && ref_rise && (!config_reg[`CFG_SWITCH] || pins_sync.ref_switch); // RULE15
  assign req_now = {cfg_wdata_i[`CTRL_POS], cfg_wdata_i[`CTRL_NEG]};
  assign req_rise = (cfg_wr_i && cfg_addr_i == `WORD_CTRL) ?
                    (req_now & ~{ctrl_reg[`CTRL_POS], ctrl_reg[`CTRL_NEG]}) : 2'h0; // RULE3
  assign ref_edge = {ref_rise, ref_fall};

  // ------------------------------------------------------------------
  // threshold window
  // ------------------------------------------------------------------
  always_comb begin
    in_window = 1'b0;
    if (config_reg[`CFG_UNSIGNED]) begin
      // cyclic: thresholds keep their written order across wrap
      if (stage45_reg <= stage67_reg) begin
        in_window = (count_reg >= stage45_reg) && (count_reg <= stage67_reg); // RULE11
      end else begin
        in_window = (count_reg >= stage45_reg) || (count_reg <= stage67_reg); // RULE11
      end
    end else if ($signed(stage45_reg) <= $signed(stage67_reg)) begin
      in_window = ($signed(count_reg) >= $signed(stage45_reg)) &&
                  ($signed(count_reg) <= $signed(stage67_reg));
    end else begin
      // signed thresholds are sorted internally
      in_window = ($signed(count_reg) >= $signed(stage67_reg)) &&
                  ($signed(count_reg) <= $signed(stage45_reg));
    end
  end

  // ------------------------------------------------------------------
  // configuration, counter and comparator
  // ------------------------------------------------------------------
  always_comb begin
    config_next = wr_cfg ? cfg_wdata_i : config_reg;
    ctrl_next = (cfg_wr_i && cfg_addr_i == `WORD_CTRL) ? cfg_wdata_i : ctrl_reg;
    stage45_next = stage45_reg;
    stage67_next = stage67_reg;
    if (cfg_wr_i && cfg_addr_i == `WORD_LO45) begin
      stage45_next[15:0] = cfg_wdata_i;
    end
    if (cfg_wr_i && cfg_addr_i == `WORD_HI45) begin
      stage45_next[31:16] = cfg_wdata_i;
    end
    if (cfg_wr_i && cfg_addr_i == `WORD_LO67) begin
      stage67_next[15:0] = cfg_wdata_i;
    end
    if (cfg_wr_i && cfg_addr_i == `WORD_HI67) begin
      stage67_next[31:16] = cfg_wdata_i;
    end
    min_diff_next = min_diff_reg;
    force_next = force_reg;
    if (ctrl_next[`CTRL_TAKE] && !ctrl_reg[`CTRL_TAKE]) begin
      min_diff_next = stage45_reg; // RULE19
      force_next = stage67_reg; // RULE19
    end
    count_next = count_reg;
    if (step) begin
      count_next = (up ^ config_reg[`CFG_DIR_INV]) ? count_reg + 32'h1 : count_reg - 32'h1; // RULE10
    end
    refd_next = refd_reg;
    if (home_evt) begin
      count_next = 32'h0; // RULE16
      refd_next = 1'b1;
    end
    if (wr_cfg) begin
      if (cfg_wdata_i[`CFG_SET_REF]) begin
        count_next = 32'h0; // RULE14
        refd_next = 1'b1; // RULE14
      end else begin
        refd_next = 1'b0; // RULE14
      end
    end
    ref_prev_next = ref_level;
    if (comp_en) begin
      comp_next = in_window ? (config_reg[`CFG_LEVEL] ^ config_reg[`CFG_INVLEVEL]) :
                  !(config_reg[`CFG_LEVEL] ^ config_reg[`CFG_INVLEVEL]); // RULE18 RULE21
    end else begin
      comp_next = dout_i; // RULE17
    end
  end

  // ------------------------------------------------------------------
  // latching, channel 0 negative edge, channel 1 positive edge
  // ------------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      state_next[k] = state_reg[k];
      cmp_next[k] = cmp_reg[k];
      hold_next[k] = hold_reg[k];
      latched_next[k] = latched_reg[k];
      valid_next[k] = valid_reg[k];
      diff[k] = hold_reg[k] - cmp_reg[k];
      accept[k] = config_reg[`CFG_UNSIGNED] ? (diff[k] > min_diff_reg) :
                  ($signed(diff[k]) > $signed(min_diff_reg)); // RULE6
      unique case (state_reg[k])
        LATCH_IDLE: begin
          if (req_rise[k]) begin
            cmp_next[k] = count_reg; // RULE3
            state_next[k] = LATCH_ARMED;
          end
        end
        LATCH_ARMED: begin
          if (latch_en && ref_edge[k]) begin
            if (min_diff_reg == 32'h0) begin
              latched_next[k] = count_reg; // RULE4
              valid_next[k] = 1'b1;
              state_next[k] = LATCH_IDLE; // RULE20
            end else begin
              hold_next[k] = count_reg; // RULE5
              state_next[k] = LATCH_CHECK;
            end
          end
        end
        LATCH_CHECK: begin
          if (accept[k]) begin
            latched_next[k] = hold_reg[k]; // RULE6
            valid_next[k] = 1'b1; // RULE6
            state_next[k] = LATCH_IDLE; // RULE20
          end else begin
            state_next[k] = LATCH_ARMED; // RULE7
          end
        end
        default: state_next[k] = LATCH_IDLE;
      endcase
      // a cleared request ends the operation and drops the valid bit
      if (cfg_wr_i && cfg_addr_i == `WORD_CTRL && !req_now[k]) begin
        state_next[k] = LATCH_IDLE; // RULE20
        // an edge in the same cycle still sets the valid bit
        valid_next[k] = valid_next[k] && !valid_reg[k]; // RULE20
      end
    end
  end

  // ------------------------------------------------------------------
  // status and read port
  // ------------------------------------------------------------------
  always_comb begin
    status_live = 16'h0;
    status_live[`STAT_REFD] = refd_reg;
    status_live[`STAT_NEG] = valid_reg[0];
    status_live[`STAT_POS] = valid_reg[1];
    rdata_next = rdata_reg;
    stat_data_next = stat_data_reg;
    if (cfg_rd_i) begin
      unique case (cfg_addr_i)
        `WORD_LO45: rdata_next = latched_reg[1][15:0];
        `WORD_HI45: rdata_next = latched_reg[1][31:16];
        `WORD_LO67: rdata_next = latched_reg[0][15:0];
        `WORD_HI67: rdata_next = latched_reg[0][31:16];
        `WORD_STATUS: begin
          rdata_next = status_live; // RULE8
          stat_data_next = status_live; // RULE8
        end
        `WORD_CONFIG: rdata_next = {MODULE_CODE, 8'h00}; // RULE9
        default: rdata_next = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= `CFG_RESET;
      ctrl_reg <= `CTRL_RESET;
      stage45_reg <= 32'h0;
      stage67_reg <= 32'h0;
      min_diff_reg <= `MIN_DIFF_RESET;
      force_reg <= 32'h0;
      count_reg <= 32'h0;
      refd_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      rdata_reg <= 16'h0;
      stat_data_reg <= 16'h0;
      comp_reg <= 1'b0;
      valid_reg <= 2'h0;
      for (int k = 0; k < 2; k++) begin
        state_reg[k] <= LATCH_IDLE;
        cmp_reg[k] <= 32'h0;
        hold_reg[k] <= 32'h0;
        latched_reg[k] <= 32'h0;
      end
    end else begin
      config_reg <= config_next;
      ctrl_reg <= ctrl_next;
      stage45_reg <= stage45_next;
      stage67_reg <= stage67_next;
      min_diff_reg <= min_diff_next;
      force_reg <= force_next;
      count_reg <= count_next;
      refd_reg <= refd_next;
      ref_prev_reg <= ref_prev_next;
      rdata_reg <= rdata_next;
      stat_data_reg <= stat_data_next;
      comp_reg <= comp_next;
      valid_reg <= valid_next;
      for (int k = 0; k < 2; k++) begin
        state_reg[k] <= state_next[k];
        cmp_reg[k] <= cmp_next[k];
        hold_reg[k] <= hold_next[k];
        latched_reg[k] <= latched_next[k];
      end
    end
  end

  assign cfg_rdata_o = rdata_reg;
  assign status_word_o = stat_data_reg;
  assign count_o = count_reg;
  assign force_value_o = force_reg;
  assign comp_out_o = comp_reg;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  homing_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    home_evt |=> count_reg == 32'h0) else $error("homing did not clear counter"); // RULE16
  comp_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !comp_en |=> comp_out_o == $past(dout_i)) else $error("output 1 not digital"); // RULE17
  window_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    comp_en && in_window |=> comp_out_o == $past(config_reg[0] ^ config_reg[2]))
    else $error("window level wrong"); // RULE18
  outside_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    comp_en && !in_window |=> comp_out_o != $past(config_reg[0] ^ config_reg[2]))
    else $error("outside level wrong"); // RULE21
  latch_priority_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (home_en || config_reg[3]) && state_reg[0] == LATCH_ARMED |=> state_reg[0] != LATCH_CHECK)
    else $error("latching ran against priority"); // RULE1
  direct_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    latch_en && state_reg[1] == LATCH_ARMED && ref_rise && min_diff_reg == 32'h0
    && !(cfg_wr_i && cfg_addr_i == `WORD_CTRL)
    |=> valid_reg[1] && latched_reg[1] == $past(count_reg)) else $error("direct latch missed"); // RULE4
  discard_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg[1] == LATCH_CHECK && !accept[1] && !(cfg_wr_i && cfg_addr_i == `WORD_CTRL)
    |=> !valid_reg[1] && state_reg[1] == LATCH_ARMED)
    else $error("short difference accepted"); // RULE7
  take_diff_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ctrl_reg[`CTRL_TAKE]) |-> min_diff_reg == $past(stage45_reg, 1) && force_reg == $past(stage67_reg, 1)
    || $past(cfg_wr_i && cfg_addr_i == `WORD_HI45)) else $error("minimum difference not taken"); // RULE19
  ident_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_rd_i && cfg_addr_i == `WORD_CONFIG |=> cfg_rdata_o[15:8] == MODULE_CODE)
    else $error("module code not returned"); // RULE9
  unref_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cfg && !cfg_wdata_i[6] |=> !refd_reg) else $error("referenced bit not cleared"); // RULE14
endmodule
`default_nettype wire

// >>> hdl/enc_latch_pkg.sv
// types of the encoder latch and comparator channel
package enc_latch_pkg;

  typedef struct packed {
    logic enc_a;
    logic enc_b;
    logic ref_pulse;
    logic ref_switch;
  } enc_pins_type;

  typedef enum logic [2:0] {
    LATCH_IDLE = 3'b001,
    LATCH_ARMED = 3'b010,
    LATCH_CHECK = 3'b100
  } latch_state_type;

endpackage

// >>> hdl/pin_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync width must be at least one");
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule
`default_nettype wire

// >>> hdl/quad_decode.sv
// fourfold quadrature edge evaluation
`timescale 1ns/1ps
`default_nettype none
module quad_decode (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic a_i,
  input wire logic b_i,
  output logic step_o,
  output logic up_o
);
  logic [1:0] prev_reg;
  logic [1:0] prev_next;
  logic step_next;
  logic up_next;
  logic step_reg;
  logic up_reg;

  // every edge of either track counts; a double change is dropped
  always_comb begin
    prev_next = {a_i, b_i};
    step_next = 1'b0;
    up_next = 1'b0;
    if ((prev_reg[1] ^ a_i) != (prev_reg[0] ^ b_i)) begin
      step_next = 1'b1;
      up_next = prev_reg[1] ^ b_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 2'h0;
      step_reg <= 1'b0;
      up_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      step_reg <= step_next;
      up_reg <= up_next;
    end
  end

  assign step_o = step_reg;
  assign up_o = up_reg;
endmodule
`default_nettype wire

// >>> test/encoder_latch_comparator_config_bench.sv
// self-checking bench of the encoder latch and comparator channel
`timescale 1ns/1ps
`default_nettype none
`include "enc_latch_cfg.svh"
module encoder_latch_comparator_config_bench;
  import enc_latch_pkg::*;
  localparam logic [7:0] CODE = 8'h3c; // arbitrary identification value
  typedef struct {
    logic [15:0] cfg;
    logic [31:0] thr1;
    logic [31:0] thr2;
    int steps;
    logic dout;
    logic [31:0] count;
    logic comp;
  } row_type;
  row_type rows[8] = '{
    '{16'h0049, 32'h2, 32'h5, 3, 1'b0, 32'h3, 1'b1},
    '{16'h004d, 32'h2, 32'h5, 3, 1'b0, 32'h3, 1'b0},
    '{16'h0049, 32'h2, 32'h5, 7, 1'b0, 32'h7, 1'b0},
    '{16'h0040, 32'h2, 32'h5, 1, 1'b1, 32'h1, 1'b1},
    '{16'h0849, 32'hffff_fffb, 32'hffff_ffff, 3, 1'b0, 32'hffff_fffd, 1'b1},
    '{16'h0449, 32'hffff_fffe, 32'h2, -1, 1'b0, 32'hffff_ffff, 1'b1},
    '{16'h0049, 32'h5, 32'h2, 3, 1'b0, 32'h3, 1'b1},
    '{16'h0449, 32'h2, 32'hffff_fff0, 6, 1'b0, 32'h6, 1'b1}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic step_up = 1'b0;
  logic step_down = 1'b0;
  logic ref_level = 1'b0;
  logic switch_level = 1'b0;
  logic dout = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [3:0] cfg_addr = 4'h0;
  logic [15:0] cfg_wdata = 16'h0000;
  enc_pins_type pins;
  logic [15:0] rdata;
  logic [15:0] status_word;
  logic [31:0] count;
  logic [31:0] force_value;
  logic comp_out;
  logic [15:0] data16;
  logic [31:0] data32;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // ------------------------------------------------------------------
  // instances and clock
  // ------------------------------------------------------------------
  encoder_model encoder_model_i (.clk_i(clk_i), .rst_i(rst_i), .up_i(step_up), .down_i(step_down),
    .ref_i(ref_level), .switch_i(switch_level), .pins_o(pins));
  enc_latch_channel #(.MODULE_CODE(CODE)) enc_latch_channel_i (.clk_i(clk_i), .rst_i(rst_i),
    .pins_i(pins), .dout_i(dout), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr),
    .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(rdata), .status_word_o(status_word), .count_o(count),
    .force_value_o(force_value), .comp_out_o(comp_out));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop;
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cyc(1);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    cyc(1);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    cyc(1);
    cfg_rd = 1'b1;
    cfg_addr = a;
    cyc(1);
    cfg_rd = 1'b0;
    d = rdata;
  endtask
  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    wr(a, d[15:0]);
    wr(a + 4'h1, d[31:16]);
  endtask
  task automatic rd32(input logic [3:0] a, output logic [31:0] d);
    rd(a, d[15:0]);
    rd(a + 4'h1, d[31:16]);
  endtask
  // single encoder steps, spaced wider than the pin synchroniser delay
  task automatic move(input int n);
    for (int i = 0; i < (n < 0 ? -n : n); i++) begin
      cyc(1);
      step_up = (n > 0);
      step_down = (n < 0);
      cyc(1);
      step_up = 1'b0;
      step_down = 1'b0;
      cyc(3);
    end
    cyc(4);
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    cyc(12);
    rst_i = 1'b0;
    cyc(2);
    chk("count", 32'h0, count);
    chk1("comp_out", 1'b0, comp_out);
    rd(`WORD_CONFIG, data16);
    chk("module code", {CODE, 8'h00}, data16);
    rd(4'h3, data16);
    chk("unmapped", 32'h0, data16);
    foreach (rows[i]) begin
      dout = rows[i].dout;
      wr32(`WORD_LO45, rows[i].thr1);
      wr32(`WORD_LO67, rows[i].thr2);
      wr(`WORD_CONFIG, rows[i].cfg);
      move(rows[i].steps);
      chk("count", rows[i].count, count);
      chk1("comp_out", rows[i].comp, comp_out);
    end
    wr(`WORD_CONFIG, 16'h0040);
    rd(`WORD_STATUS, data16);
    chk("status", 32'h0080, data16);
    chk("status word", 32'h0080, status_word);
    wr(`WORD_CONFIG, 16'h0000);
    move(2);
    rd(`WORD_STATUS, data16);
    chk("status word", 32'h0000, status_word);
    chk("count", 32'h2, count);
    // latching with zero minimum difference
    wr(`WORD_CONFIG, 16'h0040);
    move(5);
    wr(`WORD_CTRL, 16'h0800);
    move(2);
    ref_level = 1'b1;
    cyc(6);
    rd32(`WORD_LO45, data32);
    chk("pos latch", 32'h7, data32);
    rd(`WORD_STATUS, data16);
    chk("status", 32'h0880, data16);
    ref_level = 1'b0;
    move(1);
    ref_level = 1'b1;
    cyc(6);
    rd32(`WORD_LO45, data32);
    chk("pos latch", 32'h7, data32);
    wr(`WORD_CTRL, 16'h0000);
    rd(`WORD_STATUS, data16);
    chk("status", 32'h0080, data16);
    wr(`WORD_CTRL, 16'h0400);
    ref_level = 1'b0;
    cyc(6);
    rd32(`WORD_LO67, data32);
    chk("neg latch", 32'h8, data32);
    rd(`WORD_STATUS, data16);
    chk("status", 32'h0480, data16);
    // minimum difference and force value
    wr(`WORD_CTRL, 16'h0000);
    wr32(`WORD_LO45, 32'h3);
    wr32(`WORD_LO67, 32'h1234_5678);
    wr(`WORD_CTRL, 16'h0100);
    chk("force value", 32'h1234_5678, force_value);
    wr(`WORD_CTRL, 16'h0000);
    wr(`WORD_CONFIG, 16'h0040);
    wr(`WORD_CTRL, 16'h0800);
    move(3);
    ref_level = 1'b1;
    cyc(6);
    rd(`WORD_STATUS, data16);
    chk("status", 32'h0080, data16);
    rd32(`WORD_LO45, data32);
    chk("pos latch", 32'h7, data32);
    ref_level = 1'b0;
    move(1);
    ref_level = 1'b1;
    cyc(6);
    rd32(`WORD_LO45, data32);
    chk("pos latch", 32'h4, data32);
    rd(`WORD_STATUS, data16);
    chk("status", 32'h0880, data16);
    // inverted reference pulse: a falling pin is the positive edge
    wr(`WORD_CTRL, 16'h0000);
    wr(`WORD_CONFIG, 16'h00c0);
    wr(`WORD_CTRL, 16'h0800);
    move(5);
    ref_level = 1'b0;
    cyc(6);
    rd32(`WORD_LO45, data32);
    chk("pos latch", 32'h5, data32);
    // homing outranks latching; switch gating
    wr(`WORD_CTRL, 16'h0000);
    wr(`WORD_CONFIG, 16'h0010);
    wr(`WORD_CTRL, 16'h0800);
    ref_level = 1'b1;
    cyc(6);
    chk("count", 32'h0, count);
    rd(`WORD_STATUS, data16);
    chk1("pos valid", 1'b0, data16[`STAT_POS]);
    wr(`WORD_CTRL, 16'h0000);
    wr(`WORD_CONFIG, 16'h0030);
    ref_level = 1'b0;
    move(2);
    ref_level = 1'b1;
    cyc(6);
    chk("count", 32'h2, count);
    ref_level = 1'b0;
    switch_level = 1'b1;
    cyc(4);
    ref_level = 1'b1;
    cyc(6);
    chk("count", 32'h0, count);
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> test/encoder_model.sv
// quadrature encoder with reference pulse and reference enable switch
`timescale 1ns/1ps
`default_nettype none
module encoder_model
  import enc_latch_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic up_i,
  input wire logic down_i,
  input wire logic ref_i,
  input wire logic switch_i,
  output var enc_pins_type pins_o
);
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  // ------------------------------------------------------------------
  // step phase
  // ------------------------------------------------------------------
  always_comb begin
    phase_next = phase_reg;
    if (up_i) begin
      phase_next = phase_reg + 2'h1;
    end else if (down_i) begin
      phase_next = phase_reg - 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end
  // ------------------------------------------------------------------
  // pins
  // ------------------------------------------------------------------
  // gray sequence: one track changes per step, b leads a when moving up
  always_comb begin
    pins_o.enc_a = phase_reg[1];
    pins_o.enc_b = phase_reg[1] ^ phase_reg[0];
    pins_o.ref_pulse = ref_i;
    pins_o.ref_switch = switch_i;
  end
endmodule
`default_nettype wire
